// ### core/tcu_map.vh
/*
 Register offsets, field positions, reset values and codes of the timer
 capture unit. Assumes byte addressing on a 32-bit APB, one word per register.
*/
`ifndef TCU_MAP_VH
`define TCU_MAP_VH

// Register byte offsets
`define TCU_OFS_MODE      8'h00
`define TCU_OFS_CTRL_ONE  8'h04
`define TCU_OFS_IO_AB     8'h08
`define TCU_OFS_IO_CD     8'h0c
`define TCU_OFS_STATUS    8'h10
`define TCU_OFS_FILTER    8'h14
`define TCU_OFS_COUNTER   8'h18
`define TCU_OFS_GR_A      8'h1c
`define TCU_OFS_GR_B      8'h20
`define TCU_OFS_GR_C      8'h24
`define TCU_OFS_GR_D      8'h28

// timer_mode_register fields
`define TCU_MODE_RUN      0
`define TCU_MODE_BUF_C    1
`define TCU_MODE_BUF_D    2
`define TCU_MODE_FN_LO    3
`define TCU_MODE_FN_HI    4

// Operating modes
`define TCU_FN_TIMER      2'h0
`define TCU_FN_PWM        2'h1
`define TCU_FN_PWM2       2'h2

// timer_control_one fields
`define TCU_CKS_LO        0
`define TCU_CKS_HI        2
`define TCU_CTRL_OSC_ON   3
`define TCU_CTRL_EXT_DIR  4

// clock_source_select codes
`define TCU_CKS_F1        3'h0
`define TCU_CKS_F2        3'h1
`define TCU_CKS_F4        3'h2
`define TCU_CKS_F8        3'h3
`define TCU_CKS_F32       3'h4
`define TCU_CKS_EXT       3'h5
`define TCU_CKS_OSC       3'h6

// io_control fields, low channel in bits 2:0, high channel in bits 6:4
`define TCU_IO_RESET      8'h88
`define TCU_IO_CAP_LO     2
`define TCU_IO_CAP_HI     6

// filter_control fields
`define TCU_FLT_TRIG      4
`define TCU_FLT_CLK_LO    6
`define TCU_FLT_CLK_HI    7

// Edge select table: two bits {fall,rise} per code 0..3
`define TCU_EDGE_TABLE    8'hf9

`define TCU_CNT_MAX       16'hffff

`endif

// ### core/tcu_prescale.v
/*
 Free-running divider producing one-cycle ticks at f/2, f/4, f/8 and f/32.
 Assumes the block clock is the operation clock f1.
*/
`timescale 1ns/1ps

module tcu_prescale (
  // Clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // Ticks {f32, f8, f4, f2}
  output wire [3:0] tick
);

  reg [4:0] div_r;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 5'h00;
    end else begin
      div_r <= div_r + 5'h01;
    end
  end

  assign tick = {&div_r[4:0], &div_r[2:0], &div_r[1:0], div_r[0]};

endmodule

// ### core/tcu_filter.v
/*
 Three-match digital filter for one input pin, bypassable.
 Assumes the pin is synchronous to clock; sample is a one-cycle strobe.
*/
`timescale 1ns/1ps

module tcu_filter (
  // Clock and reset
  input  wire clock,
  input  wire rst_n,
  // Pin and control
  input  wire pin,
  input  wire sample,
  input  wire filt_en,
  // Filtered level
  output reg  level
);

  reg  [1:0] hist_r;
  wire [2:0] win;

  assign win = {hist_r, pin};

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hist_r <= 2'h0;
      level  <= 1'b0;
    end else if (!filt_en) begin
      // History follows the pin so enabling never accepts stale samples
      hist_r <= {pin, pin};
      level  <= pin;
    end else if (sample) begin
      hist_r <= win[1:0];
      if (win == 3'h7 || win == 3'h0) begin
        level <= pin;
      end
    end
  end

endmodule

// ### core/tcu_top.v
/*
 Timer capture unit: 16-bit up counter, clock source select, four capture
 channels with buffer chaining, compare-match buffer loads, input filters and
 an APB register slave. Assumes all pins are synchronous to clock (f1) and
 the fast oscillator clock is slower than half of clock.
*/
`timescale 1ns/1ps
`include "tcu_map.vh"

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Codes 000b-100b count f1, f2, f4, f8 or f32 ticks.
// - Code 110b with fast_osc_on counts rising edges of the 40 MHz clock.
// - Code 101b with pin set as input counts external clock rising edges.
// - buffer_c_enable makes C buffer A; buffer_d_enable makes D buffer B.
// - Buffered capture moves old A or B into C or D.
// - Buffered compare or PWM loads A or B from buffer on own match.
// - Buffered PWM2 loads B from D on A match or trigger input.
// - C or D pin edge sets its match flag even while buffering.
// - Filter accepts a new level after three matching samples.
// - Filter register picks per-input enable and the sampling clock.
// - Valid capture edge copies the counter into the channel register, except on C or D while buffering.
// - Counter increments per source tick and wraps after 65,536 counts.
// - Run bit 1 starts, 0 stops; stopped counter holds its value.
// - Capture edges and overflow raise an interrupt request pulse.
// - Software reads and writes the counter.
// - Each channel captures on rising, falling or both edges.
// - Each channel pin is either a port or a capture input.
// - Capture edge sets channel match flag; overflow sets overflow flag.
// - Unfiltered capture completes two cycles after the edge.
// - Flags stay set until software clears them.
module tcu_top #(
  parameter [7:0] EDGE_TABLE = `TCU_EDGE_TABLE
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_n,
  // APB slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  // Pins
  input  wire        channel_pin_a,
  input  wire        channel_pin_b,
  input  wire        channel_pin_c,
  input  wire        channel_pin_d,
  input  wire        pwm2_trigger_pin,
  input  wire        external_count_clock_pin,
  input  wire        fast_osc_40mhz_clock,
  // Status to the system
  output wire [3:0]  capture_pin_enable,
  output reg  [4:0]  irq_condition
);

  //////////////////////////////////////////////////////////////////////////
  // Registers
  reg        run_r;
  reg        buf_c_r;
  reg        buf_d_r;
  reg [1:0]  fn_r;
  reg [2:0]  cks_r;
  reg        osc_on_r;
  reg        ext_dir_r;
  reg [7:0]  io_ab_r;
  reg [7:0]  io_cd_r;
  reg [4:0]  flag_r;
  reg [7:0]  flt_r;
  reg [15:0] cnt_r;
  reg [15:0] gr_r [0:3];
  reg [4:0]  lvl_q_r;
  reg        ext_q_r;
  reg        osc_q_r;
  wire [3:0] pre_tick;
  wire [4:0] lvl;
  wire [4:0] pin_vec;
  wire [4:0] rise;
  wire [4:0] fall;
  wire [7:0] esel;
  wire [3:0] csel;
  wire       wr_en;
  wire       rd_setup;
  wire       timer_fn;
  reg        src_tick;
  reg        smp_tick;
  reg  [3:0] cap_hit;
  reg  [3:0] cmp_hit;
  reg        ovf_hit;
  reg  [31:0] rd_nxt;
  reg        err_nxt;
  integer i;
  integer j;

  function edge_hit;
    input [1:0] code;
    input       r;
    input       f;
    reg   [1:0] ent;
    begin
      ent      = EDGE_TABLE[code * 2 +: 2];
      edge_hit = (ent[0] & r) | (ent[1] & f);
    end
  endfunction
  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a[1:0] == 2'h0) && (a <= `TCU_OFS_GR_D);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Clock sources and filters
  tcu_prescale u_pre (
    .clock (clock),
    .rst_n (rst_n),
    .tick  (pre_tick)
  );
  always @* begin
    case (cks_r)
      `TCU_CKS_F1:  src_tick = 1'b1;
      `TCU_CKS_F2:  src_tick = pre_tick[0];
      `TCU_CKS_F4:  src_tick = pre_tick[1];
      `TCU_CKS_F8:  src_tick = pre_tick[2];
      `TCU_CKS_F32: src_tick = pre_tick[3];
      `TCU_CKS_EXT: src_tick = external_count_clock_pin & ~ext_q_r & ~ext_dir_r;
      `TCU_CKS_OSC: src_tick = fast_osc_40mhz_clock & ~osc_q_r & osc_on_r;
      default:      src_tick = 1'b0;
    endcase
  end
  always @* begin
    case (flt_r[`TCU_FLT_CLK_HI:`TCU_FLT_CLK_LO])
      2'h0:    smp_tick = 1'b1;
      2'h1:    smp_tick = pre_tick[2];
      2'h2:    smp_tick = pre_tick[3];
      default: smp_tick = src_tick;
    endcase
  end
  assign pin_vec = {pwm2_trigger_pin, channel_pin_d, channel_pin_c,
                    channel_pin_b, channel_pin_a};
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_flt
      tcu_filter u_flt (
        .clock   (clock),
        .rst_n   (rst_n),
        .pin     (pin_vec[g]),
        .sample  (smp_tick),
        .filt_en (flt_r[g]),
        .level   (lvl[g])
      );
    end
  endgenerate
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lvl_q_r <= 5'h00;
      ext_q_r <= 1'b0;
      osc_q_r <= 1'b0;
    end else begin
      lvl_q_r <= lvl;
      ext_q_r <= external_count_clock_pin;
      osc_q_r <= fast_osc_40mhz_clock;
    end
  end
  assign rise = lvl & ~lvl_q_r;
  assign fall = ~lvl & lvl_q_r;

  //////////////////////////////////////////////////////////////////////////
  // Event decode
  assign esel     = {io_cd_r[5:4], io_cd_r[1:0], io_ab_r[5:4], io_ab_r[1:0]};
  assign csel     = {io_cd_r[`TCU_IO_CAP_HI], io_cd_r[`TCU_IO_CAP_LO],
                     io_ab_r[`TCU_IO_CAP_HI], io_ab_r[`TCU_IO_CAP_LO]};
  assign timer_fn = (fn_r == `TCU_FN_TIMER);
  assign capture_pin_enable = csel & {4{timer_fn}};
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      cap_hit[i] = capture_pin_enable[i] && edge_hit(esel[i*2 +: 2], rise[i], fall[i]);
      cmp_hit[i] = run_r && src_tick && (cnt_r == gr_r[i]) && !capture_pin_enable[i];
    end
    ovf_hit = run_r && src_tick && (cnt_r == `TCU_CNT_MAX);
  end

  //////////////////////////////////////////////////////////////////////////
  // APB slave
  assign pready   = 1'b1;
  assign wr_en    = psel && penable && pwrite && addr_ok(paddr);
  assign rd_setup = psel && !penable;
  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = !addr_ok(paddr);
    case (paddr)
      `TCU_OFS_MODE:     rd_nxt[4:0] = {fn_r, buf_d_r, buf_c_r, run_r};
      `TCU_OFS_CTRL_ONE: rd_nxt[4:0] = {ext_dir_r, osc_on_r, cks_r};
      `TCU_OFS_IO_AB:    rd_nxt[7:0] = io_ab_r;
      `TCU_OFS_IO_CD:    rd_nxt[7:0] = io_cd_r;
      `TCU_OFS_STATUS:   rd_nxt[4:0] = flag_r;
      `TCU_OFS_FILTER:   rd_nxt[7:0] = flt_r;
      `TCU_OFS_COUNTER:  rd_nxt[15:0] = cnt_r;
      `TCU_OFS_GR_A:     rd_nxt[15:0] = gr_r[0];
      `TCU_OFS_GR_B:     rd_nxt[15:0] = gr_r[1];
      `TCU_OFS_GR_C:     rd_nxt[15:0] = gr_r[2];
      `TCU_OFS_GR_D:     rd_nxt[15:0] = gr_r[3];
      default:           rd_nxt = 32'h0000_0000;
    endcase
  end
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      prdata  <= rd_nxt;
      pslverr <= err_nxt;
    end
  end
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_r     <= 1'b0;
      buf_c_r   <= 1'b0;
      buf_d_r   <= 1'b0;
      fn_r      <= `TCU_FN_TIMER;
      cks_r     <= `TCU_CKS_F1;
      osc_on_r  <= 1'b0;
      ext_dir_r <= 1'b0;
      io_ab_r   <= `TCU_IO_RESET;
      io_cd_r   <= `TCU_IO_RESET;
      flt_r     <= 8'h00;
    end else if (wr_en) begin
      case (paddr)
        `TCU_OFS_MODE: begin
          run_r   <= pwdata[`TCU_MODE_RUN];
          buf_c_r <= pwdata[`TCU_MODE_BUF_C];
          buf_d_r <= pwdata[`TCU_MODE_BUF_D];
          fn_r    <= pwdata[`TCU_MODE_FN_HI:`TCU_MODE_FN_LO];
        end
        `TCU_OFS_CTRL_ONE: begin
          cks_r     <= pwdata[`TCU_CKS_HI:`TCU_CKS_LO];
          osc_on_r  <= pwdata[`TCU_CTRL_OSC_ON];
          ext_dir_r <= pwdata[`TCU_CTRL_EXT_DIR];
        end
        `TCU_OFS_IO_AB:  io_ab_r <= pwdata[7:0] | 8'h88;
        `TCU_OFS_IO_CD:  io_cd_r <= pwdata[7:0] | 8'h88;
        `TCU_OFS_FILTER: flt_r   <= {pwdata[7:6], 1'b0, pwdata[4:0]};
        default: run_r <= run_r;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Counter, flags and general registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 16'h0000;
    end else if (wr_en && paddr == `TCU_OFS_COUNTER) begin
      cnt_r <= pwdata[15:0];
    end else if (run_r && src_tick) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
  // flag sources; sticky until cleared; set beats clear
  // C and D flags set while buffering
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_r        <= 5'h00;
      irq_condition <= 5'h00;
    end else begin
      flag_r <= (flag_r & ((wr_en && paddr == `TCU_OFS_STATUS) ? pwdata[4:0] : 5'h1f))
                | {ovf_hit, cap_hit | cmp_hit};
      irq_condition <= {ovf_hit, cap_hit | cmp_hit};
    end
  end
  // Hardware transfers override a same-cycle software write
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (j = 0; j < 4; j = j + 1) begin
        gr_r[j] <= 16'h0000;
      end
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        if (wr_en && paddr == `TCU_OFS_GR_A + j * 4) begin
          gr_r[j] <= pwdata[15:0];
        end
        // capture into A and B; two cycles
        if (j < 2 && cap_hit[j]) begin
          gr_r[j] <= cnt_r;
        end
      end
      if (cap_hit[0] && buf_c_r) begin
        gr_r[2] <= gr_r[0];
      end else if (cap_hit[2] && !buf_c_r) begin
        gr_r[2] <= cnt_r;
      end
      if (cap_hit[1] && buf_d_r) begin
        gr_r[3] <= gr_r[1];
      end else if (cap_hit[3] && !buf_d_r) begin
        gr_r[3] <= cnt_r;
      end
      if (cmp_hit[0] && buf_c_r) begin
        gr_r[0] <= gr_r[2];
      end
      if (fn_r == `TCU_FN_PWM2) begin
        // load B on A match or trigger
        if (buf_d_r && (cmp_hit[0] || rise[4])) begin
          gr_r[1] <= gr_r[3];
        end
      end else if (cmp_hit[1] && buf_d_r) begin
        gr_r[1] <= gr_r[3];
      end
    end
  end

endmodule

// ### testbench/tcu_properties.sv
/*
 Port checker for the timer capture unit, bound to tcu_top.
 Assumes one clock domain and pins synchronous to clock.
*/
`timescale 1ns/1ps
module tcu_props (
  // Clock and reset
  input wire        clock,
  input wire        rst_n,
  // APB
  input wire [7:0]  paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Pins and status
  input wire        channel_pin_a,
  input wire [3:0]  capture_pin_enable,
  input wire [4:0]  irq_condition
);
  wire      acc = psel && penable;
  wire      wr_acc = acc && pwrite;
  reg       flt_a_r;
  reg [1:0] fn_r;
  // Shadow of filter enable A and operating mode
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flt_a_r <= 1'b0;
      fn_r    <= 2'h0;
    end else if (wr_acc && paddr == 8'h14) begin
      flt_a_r <= pwdata[0];
    end else if (wr_acc && paddr == 8'h00) begin
      fn_r <= pwdata[4:3];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  pready_high_a: assert property (pready)
    else $error("pready low");
  bad_addr_a: assert property (acc && (paddr > 8'h28 || paddr[1:0] != 2'h0)
    |-> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  good_addr_a: assert property (acc && paddr <= 8'h28 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  rdata_hold_a: assert property (acc ##1 !psel |-> $stable(prdata))
    else $error("read data not held");
  reset_quiet_a: assert property ($rose(rst_n) |-> capture_pin_enable == 4'h0 && irq_condition == 5'h0)
    else $error("outputs not quiet after reset");
  cap_enable_a: assert property (wr_acc && paddr == 8'h08 && fn_r == 2'h0
    |=> capture_pin_enable[0] == $past(pwdata[2])) else $error("capture enable wrong");
  ovf_pulse_a: assert property (irq_condition[4] |=> !irq_condition[4])
    else $error("overflow request not a pulse");
  cap_delay_a: assert property ($past(capture_pin_enable[0], 3) && capture_pin_enable[0]
    && !flt_a_r && irq_condition[0] |-> $past(channel_pin_a, 2) != $past(channel_pin_a, 3))
    else $error("capture request at wrong time");
  cover property (irq_condition[0]);
  cover property (irq_condition[4]);
  cover property (acc && pslverr);
endmodule

bind tcu_top tcu_props u_props (
  .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .channel_pin_a(channel_pin_a),
  .capture_pin_enable(capture_pin_enable), .irq_condition(irq_condition)
);

// ### testbench/tcu_pin_model.sv
/*
 External sources for count clock, fast oscillator and trigger pins.
 Assumes the bench pulses go for one cycle; lines idle low between bursts.
*/
`timescale 1ns/1ps
module tcu_pin_model (
  // Clock and reset
  input  wire       clock,
  input  wire       rst_n,
  // Burst request
  input  wire       go,
  input  wire [1:0] target,
  input  wire [7:0] count,
  output wire       busy,
  // Pins
  output wire       ext_clk,
  output wire       osc_clk,
  output wire       trig
);
  reg [7:0] left_r;
  reg [2:0] ph_r;
  reg [1:0] tgt_r;
  wire      hi = busy && ph_r < 3'h3;
  assign busy    = left_r != 8'h0;
  assign ext_clk = hi && tgt_r == 2'h0;
  assign osc_clk = hi && tgt_r == 2'h1;
  assign trig    = hi && tgt_r == 2'h2;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      left_r <= 8'h0;
      ph_r   <= 3'h0;
      tgt_r  <= 2'h0;
    end else if (go) begin
      left_r <= count;
      ph_r   <= 3'h0;
      tgt_r  <= target;
    end else if (busy) begin
      ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
      if (ph_r == 3'h5) begin
        left_r <= left_r - 8'h1;
      end
    end
  end
endmodule

// ### testbench/timer_input_capture_unit_test.sv
/*
 Register-level tests of the timer capture unit over APB.
 Assumes tcu_top, tcu_pin_model and the bound checker are compiled.
*/
`timescale 1ns/1ps
module timer_input_capture_unit_test;
  reg         clock = 1'b0;
  reg         rst_n = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire        pready;
  wire        pslverr;
  reg  [3:0]  pin = 4'h0;
  reg         go = 1'b0;
  reg  [1:0]  tgt = 2'h0;
  reg  [7:0]  npl = 8'h00;
  wire        busy;
  wire        ext_clk;
  wire        osc_clk;
  wire        trig;
  wire [3:0]  cpe;
  wire [4:0]  irq;
  reg  [4:0]  irq_seen = 5'h0;
  reg  [31:0] rd;
  reg  [31:0] e;
  integer     failures = 0;
  integer     checks = 0;
  integer     i;
  always #2 clock = ~clock;
  always @(posedge clock) irq_seen <= irq_seen | irq;
  tcu_top DUT (
    .clock(clock), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_pin_a(pin[0]), .channel_pin_b(pin[1]),
    .channel_pin_c(pin[2]), .channel_pin_d(pin[3]), .pwm2_trigger_pin(trig),
    .external_count_clock_pin(ext_clk), .fast_osc_40mhz_clock(osc_clk),
    .capture_pin_enable(cpe), .irq_condition(irq)
  );
  tcu_pin_model u_src (
    .clock(clock), .rst_n(rst_n), .go(go), .target(tgt), .count(npl), .busy(busy),
    .ext_clk(ext_clk), .osc_clk(osc_clk), .trig(trig)
  );
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string n, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", n, exp, seen);
      end
    end
  endtask
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] x, input string n);
    begin
      apb(1'b0, a, 32'h0);
      chk(n, rd, x);
    end
  endtask
  task pins(input [3:0] v);
    begin
      @(posedge clock);
      pin <= v;
      repeat (5) @(posedge clock);
    end
  endtask
  task burst(input [1:0] t, input [7:0] n);
    begin
      @(posedge clock);
      go <= 1'b1;
      tgt <= t;
      npl <= n;
      @(posedge clock);
      go <= 1'b0;
      repeat (2) @(posedge clock);
      while (busy) @(posedge clock);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    #200000;
    failures = failures + 1;
    test_done;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    rdc(8'h08, 32'h88, "io_ab");
    rdc(8'h0c, 32'h88, "io_cd");
    rdc(8'h10, 32'h0, "status");
    rdc(8'h2c, 32'h0, "unmapped");
    chk("slverr", pslverr, 1);
    apb(1'b1, 8'h18, 32'h1234);
    rdc(8'h18, 32'h1234, "counter");
    $display("test reset done");
    for (i = 0; i < 5; i = i + 1) begin
      apb(1'b1, 8'h04, i);
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h00, 32'h1);
      repeat (318) @(posedge clock);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      e = 320 >> ((i == 4) ? 5 : i);
      chk("cnt_src", rd + 1 >= e && rd <= e + 1, 1);
    end
    e = rd;
    repeat (10) @(posedge clock);
    rdc(8'h18, e, "held");
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h18, 32'hfff0);
    apb(1'b1, 8'h00, 32'h1);
    repeat (30) @(posedge clock);
    apb(1'b1, 8'h00, 32'h0);
    // Wrap through zero also matches all four zeroed compare registers
    rdc(8'h10, 32'h1f, "ovf");
    chk("ovf_irq", irq_seen[4], 1);
    rdc(8'h10, 32'h1f, "ovf_kept");
    apb(1'b1, 8'h10, 32'h0f);
    rdc(8'h10, 32'h0f, "ovf_clr");
    $display("test counting done");
    for (i = 0; i < 2; i = i + 1) begin
      apb(1'b1, 8'h18, 32'h0);
      apb(1'b1, 8'h04, i ? 32'h08 : 32'h05);
      apb(1'b1, 8'h04, i ? 32'h0e : 32'h05);
      apb(1'b1, 8'h00, 32'h1);
      burst(i[1:0], 8'd10);
      apb(1'b1, 8'h00, 32'h0);
      rdc(8'h18, 32'd10, "cnt_pin");
    end
    $display("test sources done");
    for (i = 0; i < 4; i = i + 1) begin
      apb(1'b1, 8'h08, 32'h04 | i);
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h18, 32'h100 + i);
      pins(4'h1);
      rdc(8'h10, {31'h0, i != 1}, "rise");
      apb(1'b1, 8'h10, 32'h0);
      pins(4'h0);
      rdc(8'h10, {31'h0, i != 0}, "fall");
      rdc(8'h1c, 32'h100 + i, "gr_a");
    end
    chk("cap_a_irq", irq_seen[0], 1);
    chk("cap_en", cpe, 4'h1);
    apb(1'b1, 8'h00, 32'h02);
    apb(1'b1, 8'h08, 32'h06);
    apb(1'b1, 8'h0c, 32'h06);
    apb(1'b1, 8'h18, 32'h1111);
    pins(4'h1);
    apb(1'b1, 8'h18, 32'h2222);
    pins(4'h0);
    rdc(8'h1c, 32'h2222, "buf_a");
    rdc(8'h24, 32'h1111, "buf_c");
    apb(1'b1, 8'h10, 32'h0);
    pins(4'h4);
    rdc(8'h10, 32'h4, "flag_c");
    rdc(8'h24, 32'h1111, "buf_c2");
    chk("cap_en2", cpe, 4'h5);
    pins(4'h0);
    apb(1'b1, 8'h14, 32'h01);
    apb(1'b1, 8'h10, 32'h0);
    @(posedge clock);
    pin <= 4'h1;
    repeat (2) @(posedge clock);
    pin <= 4'h0;
    rdc(8'h10, 32'h0, "glitch");
    pins(4'h1);
    rdc(8'h10, 32'h1, "filtered");
    apb(1'b1, 8'h14, 32'h0);
    pins(4'h0);
    $display("test capture done");
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h0c, 32'h0);
    apb(1'b1, 8'h1c, 32'h10);
    apb(1'b1, 8'h24, 32'h55);
    apb(1'b1, 8'h18, 32'h0);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h03);
    repeat (30) @(posedge clock);
    apb(1'b1, 8'h00, 32'h02);
    rdc(8'h1c, 32'h55, "cmp_load");
    apb(1'b1, 8'h00, 32'h14);
    apb(1'b1, 8'h28, 32'habc);
    apb(1'b1, 8'h20, 32'h0);
    burst(2'h2, 8'd1);
    rdc(8'h20, 32'habc, "pwm2_load");
    $display("test buffer loads done");
    test_done;
  end
endmodule
